// ---- design/iofm_monitor.sv ----
// What this block does
// (RQ1) Check every measurement against both thresholds
// (RQ2) Sort each measurement into nominal, over, under
// (RQ3) Out of range sets fault and overflow bits
// (RQ4) Voltage thresholds five percent beyond span
// (RQ5) Default and user-scaled voltage threshold values
// (RQ6) Thermal: dynamic, sensor or junction overflow
// (RQ7) Per-sensor thermal thresholds, user, millivolt
// (RQ8) One general connection fault indication
// (RQ9) Open and short resistance limits per sensor
// (RQ10) Installation keeps line resistance within maximum
// (RQ11) Terminal fault and connection fault stay consistent
// (RQ12) No wiring test in 0-5 V range
// (RQ13) Line compensation fault follows within 12 s
// (RQ14) First-order recursive filter per channel
// (RQ15) Filter setting changeable at any time
// (RQ16) Fast cycle mode bypasses the filter
// (RQ17) Coefficient table for settings zero to six
// (RQ18) Fixed scan of five 110 ms slots
// (RQ19) Results update once per channel conversion
`include "iofm_defines.svh"

module iofm_monitor #(
    parameter int CHANNELS    = 4,
    parameter int FIFO_DEPTH  = 16,
    parameter int SLOT_CYCLES = `IOFM_SLOT_CYCLES,
    parameter int WIRE_CYCLES = `IOFM_WIRE_CYCLES,
    parameter logic signed [17:0] RTD_LOW = -18'sh7D0
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Converted samples from the front end
    input  wire logic        sample_valid,
    input  wire logic [1:0]  sample_channel,
    input  wire logic        sample_saturated,
    input  wire logic [15:0] sample_value,
    output logic             sample_ready,
    // Wiring and compensation inputs
    input  wire logic [16:0] wire_ohms,
    input  wire logic [15:0] cold_junction_temp,
    input  wire logic [3:0]  line_anomaly,
    input  wire logic        terminal_missing,
    // Scan state
    output logic [2:0]       scan_slot,
    output logic             wiring_test_active,
    // Results to the application
    output logic [3:0]       channel_fault_bit,
    output logic [3:0]       range_overflow_status_bit
);
    localparam int W = 19;

    iofm_stream_if #(.WIDTH(W)) fill_s ();
    iofm_stream_if #(.WIDTH(W)) drain_s ();

    // Software-visible state, plus the internal wire and line fault flags
    logic [11:0]        filter_sel;
    logic [1:0]         ctrl;
    logic [15:0]        range_cfg;
    logic signed [15:0] user_min;
    logic signed [15:0] user_max;
    logic signed [15:0] filt [CHANNELS];
    iofm_pkg::iofm_area_type area [CHANNELS];
    logic [3:0]         ovf;
    logic [3:0]         wire_fault;
    logic [3:0]         line_fault;
    logic [3:0]         conn_fault;

    // Scan sequencer
    logic [31:0]        slot_cnt;
    logic [2:0]         next_slot;

    // Processing stage
    logic               s1_valid;
    logic [1:0]         s1_ch;
    logic               s1_sat;
    logic signed [15:0] s1_val;
    iofm_pkg::iofm_range_type s1_rng;
    logic signed [17:0] th_lo;
    logic signed [17:0] th_hi;
    logic signed [17:0] val_ext;
    logic               cj_bad;
    logic               thermal;
    iofm_pkg::iofm_area_type next_area;
    logic [10:0]        coef;
    logic signed [27:0] acc;
    logic signed [15:0] next_filt;

    // Samples enter through the buffer; a full buffer stalls the source
    assign fill_s.valid = sample_valid;
    assign fill_s.data  = {sample_saturated, sample_channel, sample_value};
    assign sample_ready = fill_s.ready;
    // One entry every other cycle, so a fast source really fills it
    assign drain_s.ready = !s1_valid;

    iofm_fifo #(.WIDTH(W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk     (clk),
        .sys_rst (sys_rst),
        .in_s    (fill_s.snk),
        .out_s   (drain_s.src)
    );

    // Register writes; filter setting is taken at any time (see RQ15)
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            filter_sel <= '0;
            ctrl       <= '0;
            range_cfg  <= '0;
            user_min   <= '0;
            user_max   <= 16'(`IOFM_FULL);
        end else if (reg_wr) begin
            unique case (reg_addr)
                `IOFM_REG_FILTER: filter_sel <= reg_wdata[11:0];
                `IOFM_REG_CTRL:   ctrl       <= reg_wdata[1:0];
                `IOFM_REG_RANGE:  range_cfg  <= reg_wdata[15:0];
                `IOFM_REG_UMIN:   user_min   <= reg_wdata[15:0];
                `IOFM_REG_UMAX:   user_max   <= reg_wdata[15:0];
                default: ;
            endcase
        end
    end

    // Register reads, data in the following cycle, unmapped reads zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= '0;
            if (reg_addr[7:4] == `IOFM_REG_FILT_HI && reg_addr[1:0] == 2'h0) begin
                reg_rdata <= {{16{filt[reg_addr[3:2]][15]}}, filt[reg_addr[3:2]]};
            end else begin
                unique case (reg_addr)
                    `IOFM_REG_FILTER: reg_rdata[11:0] <= filter_sel;
                    `IOFM_REG_CTRL:   reg_rdata[1:0]  <= ctrl;
                    `IOFM_REG_RANGE:  reg_rdata[15:0] <= range_cfg;
                    `IOFM_REG_UMIN:   reg_rdata[15:0] <= user_min;
                    `IOFM_REG_UMAX:   reg_rdata[15:0] <= user_max;
                    `IOFM_REG_STATUS: reg_rdata[11:0] <= {conn_fault, ovf, channel_fault_bit};
                    `IOFM_REG_AREA:   reg_rdata[7:0]  <= {area[3], area[2], area[1], area[0]};
                    default: ;
                endcase
            end
        end
    end

    // Fixed scan: channels 0..3 then internal selection (see RQ18)
    assign next_slot = (scan_slot == `IOFM_INT_SLOT) ? 3'h0 : 3'(scan_slot + 1'b1);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            slot_cnt  <= '0;
            scan_slot <= '0;
        end else if (slot_cnt == 32'(SLOT_CYCLES - 1)) begin
            slot_cnt  <= '0;
            scan_slot <= next_slot; // see RQ18
        end else begin
            slot_cnt <= slot_cnt + 1'b1;
        end
    end

    // The wiring test opens each channel slot, skipped in 0-5 V (see RQ12)
    assign wiring_test_active = scan_slot != `IOFM_INT_SLOT && slot_cnt < 32'(WIRE_CYCLES)
        && iofm_pkg::iofm_range_type'(range_cfg[scan_slot[1:0]*4 +: 4]) != iofm_pkg::IOFM_UNI5;

    // Open and short detection at the end of the wiring test (see RQ9)
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wire_fault <= '0;
        end else if (scan_slot != `IOFM_INT_SLOT && slot_cnt == 32'(WIRE_CYCLES - 1)) begin
            unique case (iofm_pkg::iofm_range_type'(range_cfg[scan_slot[1:0]*4 +: 4]))
                iofm_pkg::IOFM_PT1000, iofm_pkg::IOFM_NI1000, iofm_pkg::IOFM_OHM3850:
                    wire_fault[scan_slot[1:0]] <= wire_ohms > `IOFM_OPEN_1K
                        || wire_ohms <= `IOFM_SHORT_1K; // see RQ9
                iofm_pkg::IOFM_PT100, iofm_pkg::IOFM_OHM400:
                    wire_fault[scan_slot[1:0]] <= wire_ohms > `IOFM_OPEN_100
                        || wire_ohms <= `IOFM_SHORT_100; // see RQ9
                iofm_pkg::IOFM_MV, iofm_pkg::IOFM_TC_K, iofm_pkg::IOFM_TC_J:
                    wire_fault[scan_slot[1:0]] <= wire_ohms >= `IOFM_OPEN_TC; // see RQ9
                default:
                    wire_fault[scan_slot[1:0]] <= 1'b0; // see RQ12
            endcase
        end
    end

    // Line compensation is measured in the internal slot, once per scan,
    // so a change shows within one 550 ms scan, well inside 12 s
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            line_fault <= '0;
        end else if (scan_slot == `IOFM_INT_SLOT && slot_cnt == 32'(SLOT_CYCLES - 1)) begin
            line_fault <= line_anomaly; // see RQ13
        end
    end

    // Per-channel fault combination
    for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
        iofm_pkg::iofm_range_type rng;
        logic                     rtd;
        assign rng = iofm_pkg::iofm_range_type'(range_cfg[c*4 +: 4]);
        assign rtd = rng inside {iofm_pkg::IOFM_PT100, iofm_pkg::IOFM_PT1000,
                                 iofm_pkg::IOFM_NI1000};
        // One general indication; a missing terminal also shows here outside 0-5 V (see RQ8) (see RQ11)
        assign conn_fault[c] = (rng != iofm_pkg::IOFM_UNI5)
            && (wire_fault[c] || (rtd && line_fault[c]) || terminal_missing); // see RQ12
        assign channel_fault_bit[c] = ovf[c] || conn_fault[c] || terminal_missing; // see RQ3
        assign range_overflow_status_bit[c] = ovf[c];
    end

    // Threshold selection for the channel under processing (see RQ1)
    assign s1_rng  = iofm_pkg::iofm_range_type'(range_cfg[s1_ch*4 +: 4]);
    assign thermal = s1_rng inside {iofm_pkg::IOFM_TC_K, iofm_pkg::IOFM_TC_J,
        iofm_pkg::IOFM_NI1000, iofm_pkg::IOFM_PT100, iofm_pkg::IOFM_PT1000};
    assign val_ext = 18'(s1_val);

    always_comb begin
        logic signed [17:0] span;
        span  = 18'(user_max) - 18'(user_min);
        th_lo = `IOFM_UNI_LO;
        th_hi = `IOFM_NORM_HI;
        unique case (s1_rng)
            iofm_pkg::IOFM_BIP10, iofm_pkg::IOFM_BIP5: begin
                // Margin is five percent of the half span (see RQ4) (see RQ5)
                th_lo = ctrl[`IOFM_CTRL_USER] ? 18'(user_min) - span / (`IOFM_MARGIN_DIV * 18'sh2)
                                             : -`IOFM_NORM_HI;
                th_hi = ctrl[`IOFM_CTRL_USER] ? 18'(user_max) + span / (`IOFM_MARGIN_DIV * 18'sh2)
                                             : `IOFM_NORM_HI;
            end
            iofm_pkg::IOFM_UNI10, iofm_pkg::IOFM_UNI5, iofm_pkg::IOFM_V1_5: begin
                // Unipolar margin is five percent of the full span (see RQ5)
                th_lo = ctrl[`IOFM_CTRL_USER] ? 18'(user_min) - span / `IOFM_MARGIN_DIV : `IOFM_UNI_LO;
                th_hi = ctrl[`IOFM_CTRL_USER] ? 18'(user_max) + span / `IOFM_MARGIN_DIV : `IOFM_NORM_HI;
            end
            iofm_pkg::IOFM_MV: begin
                th_lo = ctrl[`IOFM_CTRL_USER] ? 18'(user_min) : `IOFM_MV_LO; // see RQ7
                th_hi = ctrl[`IOFM_CTRL_USER] ? 18'(user_max) : `IOFM_FULL;
            end
            iofm_pkg::IOFM_OHM400, iofm_pkg::IOFM_OHM3850: begin
                th_lo = ctrl[`IOFM_CTRL_USER] ? 18'(user_min) : `IOFM_ZERO;
                th_hi = ctrl[`IOFM_CTRL_USER] ? 18'(user_max) : `IOFM_FULL;
            end
            iofm_pkg::IOFM_TC_K: begin
                th_lo = `IOFM_TCK_LO; // see RQ7
                th_hi = `IOFM_TCK_HI;
            end
            iofm_pkg::IOFM_TC_J: begin
                th_lo = `IOFM_TCJ_LO;
                th_hi = `IOFM_TCJ_HI;
            end
            iofm_pkg::IOFM_NI1000: begin
                th_lo = `IOFM_NI_LO;
                th_hi = `IOFM_NI_HI;
            end
            iofm_pkg::IOFM_PT100: begin
                th_lo = RTD_LOW;
                th_hi = `IOFM_PT100_HI;
            end
            iofm_pkg::IOFM_PT1000: begin
                th_lo = RTD_LOW;
                th_hi = `IOFM_PT1000_HI;
            end
            default: ;
        endcase
        // Thermal ranges in user mode span 0..10000 (see RQ7)
        if (thermal && ctrl[`IOFM_CTRL_USER]) begin
            th_lo = `IOFM_ZERO;
            th_hi = `IOFM_FULL;
        end
    end

    // Cold junction window applies to thermocouples and the millivolt range (see RQ6)
    assign cj_bad = (s1_rng inside {iofm_pkg::IOFM_TC_K, iofm_pkg::IOFM_TC_J, iofm_pkg::IOFM_MV})
        && ($signed(cold_junction_temp) < `IOFM_CJ_LO || $signed(cold_junction_temp) > `IOFM_CJ_HI);

    // Area decision; saturation of the converter counts as overflow (see RQ2) (see RQ6)
    always_comb begin
        if (val_ext > th_hi || (s1_sat && !s1_val[15]) || (cj_bad && !s1_val[15])) begin
            next_area = iofm_pkg::IOFM_OVER;
        end else if (val_ext < th_lo || s1_sat || cj_bad) begin
            next_area = iofm_pkg::IOFM_UNDER;
        end else begin
            next_area = iofm_pkg::IOFM_NOMINAL;
        end
    end

    // Coefficient lookup; the unused eighth code filters as zero (see RQ17)
    always_comb begin
        unique case (filter_sel[s1_ch*3 +: 3])
            3'h1:    coef = `IOFM_COEF_1;
            3'h2:    coef = `IOFM_COEF_2;
            3'h3:    coef = `IOFM_COEF_3;
            3'h4:    coef = `IOFM_COEF_4;
            3'h5:    coef = `IOFM_COEF_5;
            3'h6:    coef = `IOFM_COEF_6;
            default: coef = '0;
        endcase
    end

    // New = a * old + (1 - a) * raw, Q10 with truncation (see RQ14)
    assign acc = $signed({17'h0, coef}) * 28'(filt[s1_ch])
               + $signed({17'h0, `IOFM_COEF_ONE - coef}) * 28'(s1_val);
    assign next_filt = ctrl[`IOFM_CTRL_FAST] ? s1_val : acc[25:10]; // see RQ16

    // Take one sample from the buffer
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1_valid <= 1'b0;
            s1_ch    <= '0;
            s1_sat   <= 1'b0;
            s1_val   <= '0;
        end else begin
            s1_valid <= drain_s.valid && drain_s.ready;
            if (drain_s.valid && drain_s.ready) begin
                {s1_sat, s1_ch, s1_val} <= drain_s.data;
            end
        end
    end

    // Results change only on a finished conversion (see RQ19)
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ovf <= '0;
            for (int i = 0; i < CHANNELS; i++) begin
                filt[i] <= '0;
                area[i] <= iofm_pkg::IOFM_NOMINAL;
            end
        end else if (s1_valid) begin
            ovf[s1_ch]  <= next_area != iofm_pkg::IOFM_NOMINAL; // see RQ3
            area[s1_ch] <= next_area;
            filt[s1_ch] <= next_filt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_convert;
        s1_valid ##0 (next_area != iofm_pkg::IOFM_NOMINAL);
    endsequence
    sequence s_flagged;
        range_overflow_status_bit[$past(s1_ch)] && channel_fault_bit[$past(s1_ch)];
    endsequence

    a_overflow_sets_fault : assert property (s_convert |=> s_flagged) // see RQ3
        else $error("overflow did not raise both bits");
    a_above_upper_over : assert property (s1_valid && val_ext > th_hi |=>
        area[$past(s1_ch)] == iofm_pkg::IOFM_OVER) // see RQ2
        else $error("value above upper threshold not overflow");
    a_bipolar_default : assert property (s1_valid && s1_rng == iofm_pkg::IOFM_BIP10
        && !ctrl[`IOFM_CTRL_USER] |-> th_hi == 18'sh2904 && th_lo == -18'sh2904) // see RQ5
        else $error("bipolar default thresholds wrong");
    a_uni5_no_test : assert property (wiring_test_active |->
        range_cfg[scan_slot[1:0]*4 +: 4] != 4'h3) // see RQ12
        else $error("wiring test run in 0-5 V range");
    a_fast_raw : assert property (s1_valid && ctrl[`IOFM_CTRL_FAST] |=>
        filt[$past(s1_ch)] == $past(s1_val)) // see RQ16
        else $error("fast cycle did not bypass filter");
    a_no_filter_raw : assert property (s1_valid && filter_sel[s1_ch*3 +: 3] == 3'h0 |=>
        filt[$past(s1_ch)] == $past(s1_val)) // see RQ17
        else $error("setting zero did not pass raw value");
    a_status_hold : assert property (!s1_valid |=> $stable(ovf) && $stable(area[0])) // see RQ19
        else $error("status changed without conversion");
    a_slot_order : assert property (slot_cnt == 32'(SLOT_CYCLES - 1) |=>
        scan_slot == (($past(scan_slot) == 3'h4) ? 3'h0 : $past(scan_slot) + 3'h1)) // see RQ18
        else $error("scan slot out of order");
    a_wire_window : assert property (scan_slot != 3'h4 && slot_cnt == 32'h0
        && range_cfg[scan_slot[1:0]*4 +: 4] != 4'h3 |-> wiring_test_active) // see RQ18
        else $error("wiring test not at slot start");
endmodule

// ---- design/iofm_defines.svh ----
`ifndef IOFM_DEFINES_SVH
`define IOFM_DEFINES_SVH

// Clock rate and scan timing
`define IOFM_CLK_KHZ      125000
`define IOFM_SCAN_MS      550
`define IOFM_SLOT_MS      110
`define IOFM_WIRE_MS      4
`define IOFM_SLOT_CYCLES  (`IOFM_SLOT_MS * `IOFM_CLK_KHZ)
`define IOFM_WIRE_CYCLES  (`IOFM_WIRE_MS * `IOFM_CLK_KHZ)
`define IOFM_SLOTS        (`IOFM_SCAN_MS / `IOFM_SLOT_MS)
`define IOFM_INT_SLOT     3'h4

// Register offsets
`define IOFM_REG_FILTER   8'h00
`define IOFM_REG_CTRL     8'h04
`define IOFM_REG_RANGE    8'h08
`define IOFM_REG_UMIN     8'h0C
`define IOFM_REG_UMAX     8'h10
`define IOFM_REG_STATUS   8'h14
`define IOFM_REG_AREA     8'h18
`define IOFM_REG_FILT_HI  4'h2

// Control fields
`define IOFM_CTRL_FAST    0
`define IOFM_CTRL_USER    1

// Default-scaling thresholds
`define IOFM_NORM_HI      18'sh2904
`define IOFM_UNI_LO       (-18'sh1F4)
`define IOFM_MV_LO        (-18'sh810)
`define IOFM_FULL         18'sh2710
`define IOFM_ZERO         18'sh0
`define IOFM_TCK_LO       (-18'shA8C)
`define IOFM_TCK_HI       18'sh3598
`define IOFM_TCJ_LO       (-18'sh834)
`define IOFM_TCJ_HI       18'sh299A
`define IOFM_NI_LO        (-18'sh258)
`define IOFM_NI_HI        18'sh9C4
`define IOFM_PT100_HI     18'sh2134
`define IOFM_PT1000_HI    18'sh1F40
`define IOFM_MARGIN_DIV   18'sh14
`define IOFM_CJ_LO        (-16'sh32)
`define IOFM_CJ_HI        16'sh352

// Connection limits in ohms
`define IOFM_OPEN_1K      17'hF0A
`define IOFM_SHORT_1K     17'h96
`define IOFM_OPEN_100     17'h190
`define IOFM_SHORT_100    17'hF
`define IOFM_OPEN_TC      17'h186A0

// Filter coefficients, Q10
`define IOFM_COEF_ONE     11'h400
`define IOFM_COEF_1       11'h300
`define IOFM_COEF_2       11'h380
`define IOFM_COEF_3       11'h3BF
`define IOFM_COEF_4       11'h3E0
`define IOFM_COEF_5       11'h3F0
`define IOFM_COEF_6       11'h3F8

`endif

// ---- design/iofm_pkg.sv ----
package iofm_pkg;
    // Input range selection per channel
    typedef enum logic [3:0] {
        IOFM_BIP10, IOFM_UNI10, IOFM_BIP5, IOFM_UNI5, IOFM_V1_5, IOFM_MV,
        IOFM_OHM400, IOFM_OHM3850, IOFM_TC_K, IOFM_TC_J, IOFM_NI1000,
        IOFM_PT100, IOFM_PT1000
    } iofm_range_type;

    // Measurement area of the last conversion
    typedef enum logic [1:0] {
        IOFM_NOMINAL, IOFM_OVER, IOFM_UNDER
    } iofm_area_type;
endpackage

// ---- design/iofm_stream_if.sv ----
interface iofm_stream_if #(parameter int WIDTH = 19);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ---- design/iofm_fifo.sv ----
module iofm_fifo #(
    parameter int WIDTH = 19,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Fill and drain sides
    iofm_stream_if.snk in_s,
    iofm_stream_if.src out_s
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    // Honest flags: full refuses, empty shows no valid
    assign in_s.ready  = count != (AW+1)'(DEPTH);
    assign out_s.valid = count != '0;
    assign out_s.data  = mem[rd_ptr];
    assign push        = in_s.valid && in_s.ready;
    assign pop         = out_s.valid && out_s.ready;

    // Storage has no reset; only pointers and count need one
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_s.data;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) wr_ptr <= AW'(wr_ptr + 1'b1);
            if (pop) rd_ptr <= AW'(rd_ptr + 1'b1);
            count <= (AW+1)'(count + push - pop);
        end
    end

    a_fifo_full_refuse : assert property (@(posedge clk) disable iff (sys_rst)
        (count == (AW+1)'(DEPTH) && in_s.valid && !pop) |=> count == (AW+1)'(DEPTH))
        else $error("fifo accepts while full");
    a_fifo_count_track : assert property (@(posedge clk) disable iff (sys_rst)
        (push && !pop) |=> count == $past(count) + 1'b1)
        else $error("fifo count missed a push");
endmodule

// ---- verification/iofm_src_model.sv ----
module iofm_src_model (
    // Clock, reset and burst control from the bench
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        go,
    input  wire logic [5:0]  count,
    input  wire logic [1:0]  ch,
    input  wire logic        sat,
    input  wire logic [15:0] val,
    // Stream toward the monitor
    input  wire logic        sample_ready,
    output logic             sample_valid,
    output logic [1:0]       sample_channel,
    output logic             sample_saturated,
    output logic [15:0]      sample_value
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] left;

    // Offer stays up until taken, so a full buffer simply stalls the burst
    always_ff @(posedge clk) begin
        if (sys_rst) left <= 6'h00;
        else if (go) left <= count;
        else if (sample_valid && sample_ready) left <= left - 6'h01;
    end
    // Idle lines show the inverse, so stale data never passes for a sample
    assign sample_valid     = (left != 6'h00);
    assign sample_channel   = sample_valid ? ch : ~ch;
    assign sample_saturated = sample_valid ? sat : ~sat;
    assign sample_value     = sample_valid ? val : ~val;
endmodule

// ---- verification/iofm_monitor_tb.sv ----
module iofm_monitor_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, sys_rst, reg_wr, reg_rd, go, sat, terminal_missing, wiring_test_active, wchk, saw_full, bad_wire;
    logic        sample_ready, sample_valid, sample_saturated, saw_wire;
    logic [1:0]  ch, sample_channel;
    logic [2:0]  scan_slot;
    logic [3:0]  line_anomaly, channel_fault_bit, range_overflow_status_bit;
    logic [5:0]  count;
    logic [7:0]  reg_addr;
    logic [15:0] val, cold_junction_temp, sample_value;
    logic [16:0] wire_ohms;
    logic [31:0] reg_wdata, reg_rdata;
    int          mismatches = 0, n_checks = 0;

    // Short slots keep one scan near 200 cycles
    iofm_monitor #(.SLOT_CYCLES(40), .WIRE_CYCLES(4)) iofm_monitor_i (
        .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sample_valid(sample_valid), .sample_channel(sample_channel),
        .sample_saturated(sample_saturated), .sample_value(sample_value), .sample_ready(sample_ready),
        .wire_ohms(wire_ohms), .cold_junction_temp(cold_junction_temp), .line_anomaly(line_anomaly),
        .terminal_missing(terminal_missing), .scan_slot(scan_slot), .wiring_test_active(wiring_test_active),
        .channel_fault_bit(channel_fault_bit), .range_overflow_status_bit(range_overflow_status_bit));
    iofm_src_model iofm_src_model_i (.clk(clk), .sys_rst(sys_rst), .go(go), .count(count), .ch(ch), .sat(sat),
        .val(val), .sample_ready(sample_ready), .sample_valid(sample_valid), .sample_channel(sample_channel),
        .sample_saturated(sample_saturated), .sample_value(sample_value));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Note a full buffer, and any wiring test in the slot of the 0-5 V channel
    always @(posedge clk) begin
        if (!sample_ready) saw_full <= 1'b1;
        if (wchk && scan_slot == 3'h3 && wiring_test_active) bad_wire <= 1'b1;
        if (wchk && scan_slot == 3'h2 && wiring_test_active) saw_wire <= 1'b1;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stand from the cycle after the strobe until the next read
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", reg_rdata, exp);
    endtask
    // Burst of n equal samples; the wait covers a full 16-deep drain at one pop per two cycles
    task automatic send(input logic [1:0] c, input logic [15:0] v, input logic s, input logic [5:0] n);
        int k;
        @(posedge clk);
        ch <= c;
        val <= v;
        sat <= s;
        count <= n;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        for (k = 0; k < 400; k++) begin
            @(posedge clk);
            #1;
            if (!sample_valid) break;
        end
        if (k == 400) begin
            mismatches++;
            wrap_up();
        end
        repeat (40) @(posedge clk);
        #1;
    endtask

    initial begin
        sys_rst = 1'b1;
        {reg_wr, reg_rd, go, sat, terminal_missing, wchk, saw_full, bad_wire, saw_wire} = '0;
        {ch, count, val, reg_addr, reg_wdata, line_anomaly, cold_junction_temp, wire_ohms} = '0;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        // Reset values, read-only status and an unmapped place
        rd(8'h10, 32'h00002710);
        wr(8'h14, 32'hFFFFFFFF);
        rd(8'h14, 32'h00000000);
        rd(8'h3C, 32'h00000000);
        // Ranges: ch0 bipolar 10 V, ch1 unipolar 10 V, ch2 type K, ch3 0-5 V
        wr(8'h08, 32'h00003810);
        @(posedge clk);
        wchk <= 1'b1;
        wr(8'h00, 32'h00000001);
        send(2'h0, 16'h2904, 1'b0, 6'h01);
        rd(8'h20, 32'h00000A41);
        rd(8'h18, 32'h00000000);
        send(2'h0, 16'h2905, 1'b0, 6'h01);
        rd(8'h20, 32'h000011F2);
        rd(8'h18, 32'h00000001);
        chk("fault", {28'h0, channel_fault_bit}, 32'h1);
        chk("ovf", {28'h0, range_overflow_status_bit}, 32'h1);
        // Fast cycle hands raw values through
        wr(8'h04, 32'h00000001);
        send(2'h0, 16'hD6FB, 1'b0, 6'h01);
        rd(8'h20, 32'hFFFFD6FB);
        rd(8'h18, 32'h00000002);
        send(2'h1, 16'hFE0B, 1'b0, 6'h01);
        rd(8'h18, 32'h0000000A);
        send(2'h1, 16'hFE0C, 1'b0, 6'h01);
        rd(8'h18, 32'h00000002);
        // User scaling 0..10000 gives a bipolar margin of 250
        wr(8'h04, 32'h00000003);
        send(2'h0, 16'h280B, 1'b0, 6'h01);
        rd(8'h18, 32'h00000001);
        send(2'h0, 16'h280A, 1'b0, 6'h01);
        rd(8'h18, 32'h00000000);
        // Thermal: junction out of window, saturation, sensor limit
        wr(8'h04, 32'h00000001);
        cold_junction_temp <= 16'h0384;
        send(2'h2, 16'h0064, 1'b0, 6'h01);
        rd(8'h18, 32'h00000010);
        cold_junction_temp <= 16'h00C8;
        send(2'h2, 16'hFFF6, 1'b1, 6'h01);
        rd(8'h18, 32'h00000020);
        send(2'h2, 16'h3599, 1'b0, 6'h01);
        rd(8'h18, 32'h00000010);
        send(2'h2, 16'h3598, 1'b0, 6'h01);
        rd(8'h18, 32'h00000000);
        // Open thermocouple, then restored, over whole scans
        wire_ohms <= 17'h186A0;
        repeat (210) @(posedge clk);
        rd(8'h14, 32'h00000404);
        wire_ohms <= 17'h1869F;
        repeat (210) @(posedge clk);
        rd(8'h14, 32'h00000000);
        terminal_missing <= 1'b1;
        @(posedge clk);
        #1;
        chk("fault", {28'h0, channel_fault_bit}, 32'hF);
        rd(8'h14, 32'h0000070F);
        terminal_missing <= 1'b0;
        // Burst overruns the buffer; the source stalls until it drains
        send(2'h1, 16'h0064, 1'b0, 6'h28);
        chk("full", {31'h0, saw_full}, 32'h1);
        chk("ready", {31'h0, sample_ready}, 32'h1);
        rd(8'h24, 32'h00000064);
        chk("wiring", {31'h0, bad_wire}, 32'h0);
        chk("wire test", {31'h0, saw_wire}, 32'h1);
        wrap_up();
    end
endmodule
